// >>> rtl/fie_pkg.sv
// Constants, types and the state record shared by the flow and increment execution block.
package fie_pkg;

  // Clock edges per documented machine cycle.
  localparam int CLK_PER_CYC = 3;

  // Opcodes handled by this block.
  localparam logic [7:0] OP_EXIT = 8'h2F;
  localparam logic [7:0] OP_IDLE = 8'h6F;
  localparam logic [7:0] OP_INC_R = 8'h20;
  localparam logic [7:0] OP_INC_IR = 8'h21;
  localparam logic [7:0] OP_WORD_PLUS_ONE_RR = 8'hA0;
  localparam logic [7:0] OP_WORD_PLUS_ONE_IR = 8'hA1;
  localparam logic [7:0] OP_JP_IRR = 8'h30;
  localparam logic [7:0] OP_SERVICE_RETURN = 8'hBF;
  localparam logic [3:0] LO_INC_WR = 4'hE;
  localparam logic [3:0] LO_JP_CC = 4'hD;
  localparam logic [3:0] LO_JR_CC = 4'hB;

  // Documented machine cycles per instruction.
  localparam int CYC_EXIT_INT = 14;
  localparam int CYC_EXIT_EXT = 16;
  localparam int CYC_IDLE = 4;
  localparam int CYC_INC = 4;
  localparam int CYC_WORD_PLUS_ONE = 8;
  localparam int CYC_SERVICE_RETURN_INT = 10;
  localparam int CYC_SERVICE_RETURN_EXT = 12;
  localparam int CYC_SERVICE_RETURN_FAST = 6;
  localparam int CYC_JP = 8;
  localparam int CYC_JR = 6;
  localparam int CYC_OTHER = 4;

  // Clock budgets derived from the cycle figures.
  localparam logic [7:0] BUD_EXIT_INT = 8'(CYC_EXIT_INT * CLK_PER_CYC);
  localparam logic [7:0] BUD_EXIT_EXT = 8'(CYC_EXIT_EXT * CLK_PER_CYC);
  localparam logic [7:0] BUD_IDLE = 8'(CYC_IDLE * CLK_PER_CYC);
  localparam logic [7:0] BUD_INC = 8'(CYC_INC * CLK_PER_CYC);
  localparam logic [7:0] BUD_WORD_PLUS_ONE = 8'(CYC_WORD_PLUS_ONE * CLK_PER_CYC);
  localparam logic [7:0] BUD_SERVICE_RETURN_INT = 8'(CYC_SERVICE_RETURN_INT * CLK_PER_CYC);
  localparam logic [7:0] BUD_SERVICE_RETURN_EXT = 8'(CYC_SERVICE_RETURN_EXT * CLK_PER_CYC);
  localparam logic [7:0] BUD_SERVICE_RETURN_FAST = 8'(CYC_SERVICE_RETURN_FAST * CLK_PER_CYC);
  localparam logic [7:0] BUD_JP = 8'(CYC_JP * CLK_PER_CYC);
  localparam logic [7:0] BUD_JR = 8'(CYC_JR * CLK_PER_CYC);
  localparam logic [7:0] BUD_OTHER = 8'(CYC_OTHER * CLK_PER_CYC);

  // Condition flag positions, and the enable bit of the interrupt control register.
  localparam int FLG_C = 7;
  localparam int FLG_Z = 6;
  localparam int FLG_S = 5;
  localparam int FLG_V = 4;
  localparam int FLG_FIS = 1;
  localparam int GIC_EN = 0;

  // Software register indices.
  localparam logic [2:0] REG_PC = 3'h0;
  localparam logic [2:0] REG_IP = 3'h1;
  localparam logic [2:0] REG_SP = 3'h2;
  localparam logic [2:0] REG_FLAGS = 3'h3;
  localparam logic [2:0] REG_GIC = 3'h4;
  localparam logic [2:0] REG_CTRL = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h6;

  // Control and status bit positions.
  localparam int CTRL_EXT_STK = 0;
  localparam int CTRL_FAST = 1;
  localparam int CTRL_RUN = 2;
  localparam int STS_HALT = 0;
  localparam int STS_BUSY = 1;
  localparam int STS_ILLEGAL = 2;

  // Reset values.
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_IP = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h0100;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_GIC = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;

  typedef enum logic [1:0] {SPC_PROG, SPC_REG, SPC_DATA} fie_space_t;

  typedef struct packed {
    logic req;
    logic we;
    fie_space_t space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fie_mem_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
  } fie_sw_t;

  typedef enum logic [3:0] {
    ST_STOP, ST_FETCH, ST_WAIT, ST_DECODE, ST_OPND, ST_PTR, ST_RD1, ST_RD2,
    ST_RD3, ST_RD4, ST_WR2, ST_IRQ2, ST_IRQ3, ST_PAD, ST_HALT
  } fie_st_t;

  typedef struct packed {
    fie_st_t st;
    fie_st_t ret;
    logic [7:0] cnt;
    logic [7:0] budget;
    logic [7:0] op;
    logic [7:0] tmp;
    logic [15:0] addr;
    logic [15:0] pc;
    logic [15:0] ip;
    logic [15:0] sp;
    logic [7:0] flags;
    logic [7:0] shadow;
    logic [7:0] gic;
    logic [7:0] ctrl;
    logic illegal;
    logic halt_pend;
    logic halt;
    fie_mem_t mem;
    logic [15:0] rdata;
    logic irq_meta;
    logic irq_sync;
  } fie_core_t;

endpackage

// >>> rtl/fie_cond.sv
// Branch condition decoder: four-bit code against the flags.
module fie_cond (
  input wire logic [3:0] code,
  input wire logic [7:0] flags,
  output logic taken
);

  logic c;
  logic z;
  logic s;
  logic v;

  assign c = flags[fie_pkg::FLG_C];
  assign z = flags[fie_pkg::FLG_Z];
  assign s = flags[fie_pkg::FLG_S];
  assign v = flags[fie_pkg::FLG_V];

  // Upper half of the table is the negation of the lower half, with code 8 the negation of code 0.
  always_comb begin
    case (code)
      4'h0: taken = 1'b0;
      4'h1: taken = s ^ v;
      4'h2: taken = z | (s ^ v);
      4'h3: taken = c | z;
      4'h4: taken = v;
      4'h5: taken = s;
      4'h6: taken = z;
      4'h7: taken = c;
      4'h8: taken = 1'b1; // RULE19
      4'h9: taken = ~(s ^ v);
      4'hA: taken = ~(z | (s ^ v));
      4'hB: taken = ~(c | z);
      4'hC: taken = ~v;
      4'hD: taken = ~s;
      4'hE: taken = ~z;
      default: taken = ~c;
    endcase
  end

endmodule

// >>> rtl/fie_incr.sv
// Byte or word increment with zero, sign and overflow results.
module fie_incr (
  input wire logic [15:0] value,
  input wire logic word,
  output logic [15:0] result,
  output logic zero,
  output logic neg,
  output logic ovf
);

  // Byte mode works on the low byte only; the high byte of the result reads zero.
  always_comb begin
    if (word) begin
      result = value + 16'h0001; // RULE7
      zero = (result == 16'h0000);
      neg = result[15];
      ovf = (value == 16'h7FFF);
    end else begin
      result = {8'h00, value[7:0] + 8'h01}; // RULE6
      zero = (result[7:0] == 8'h00);
      neg = result[7];
      ovf = (value[7:0] == 8'h7F);
    end
  end

endmodule

// >>> rtl/fie_core.sv
// Execution core for threaded exit, idle, increments, service return and branches.
// Behaviour
// (RULE1) Exit pops thread pointer, stack pointer plus two
// (RULE2) Exit loads counter from thread word, flags kept
// (RULE3) Halt opcode gates CPU clock, four cycles
// (RULE4) Halted core wakes on interrupt or reset
// (RULE5) Software follows halt with three no_operation
// (RULE6) Byte increment sets zero, sign, overflow only
// (RULE7) Word increment on even pair, same flags
// (RULE8) Software tests word zero by ORing bytes
// (RULE9) Service return restores flags, counter, enables interrupts
// (RULE10) Normal return only when fast flag clear
// (RULE11) Return restores flags to pre-interrupt values
// (RULE12) Fast interrupt swaps counter and thread pointer
// (RULE13) Software avoids clearing pending just before return
// (RULE14) Absolute branch loads direct address when true
// (RULE15) Register-pair absolute branch loads counter
// (RULE16) Relative branch adds signed byte when true
// (RULE17) Relative base is byte after instruction
// (RULE18) Control bit zero is global interrupt enable
// (RULE19) Condition table standard, code eight always
//
// Design decisions made here: the address map and the plain strobed port.
module fie_core (
  input wire logic clk,
  input wire logic rst,
  input wire fie_pkg::fie_sw_t sw,
  output logic [15:0] sw_rdata,
  input wire logic irq_pin,
  input wire logic [15:0] irq_vector,
  output fie_pkg::fie_mem_t mem,
  input wire logic [7:0] mem_rdata,
  output logic cpu_halt
);

  fie_pkg::fie_core_t st_r;
  fie_pkg::fie_core_t st_nxt;
  fie_pkg::fie_space_t stk_spc;
  logic cond_true;
  logic [15:0] inc_in;
  logic inc_word;
  logic [15:0] inc_res;
  logic inc_z;
  logic inc_s;
  logic inc_v;
  logic ext_stk;

  assign ext_stk = st_r.ctrl[fie_pkg::CTRL_EXT_STK];
  assign stk_spc = ext_stk ? fie_pkg::SPC_DATA : fie_pkg::SPC_REG;
  assign inc_word = (st_r.op == fie_pkg::OP_WORD_PLUS_ONE_RR) || (st_r.op == fie_pkg::OP_WORD_PLUS_ONE_IR);
  assign inc_in = inc_word ? {st_r.tmp, mem_rdata} : {8'h00, mem_rdata};

  fie_cond u_cond (
    .code(st_r.op[7:4]),
    .flags(st_r.flags),
    .taken(cond_true)
  );

  fie_incr u_incr (
    .value(inc_in),
    .word(inc_word),
    .result(inc_res),
    .zero(inc_z),
    .neg(inc_s),
    .ovf(inc_v)
  );

  // Memory request builder; every read returns data two edges after it is chosen.
  function automatic fie_pkg::fie_mem_t acc(input logic we, input fie_pkg::fie_space_t spc,
                                            input logic [15:0] a, input logic [7:0] d);
    fie_pkg::fie_mem_t m;
    m.req = 1'b1;
    m.we = we;
    m.space = spc;
    m.addr = a;
    m.wdata = d;
    return m;
  endfunction

  // Next-state logic; software accesses first so that core updates win a collision.
  always_comb begin
    st_nxt = st_r;
    st_nxt.mem = '0;
    st_nxt.rdata = 16'h0000;
    st_nxt.cnt = st_r.cnt + 8'h01;
    st_nxt.irq_meta = irq_pin;
    st_nxt.irq_sync = st_r.irq_meta;
    if (sw.rd) begin
      case (sw.addr)
        fie_pkg::REG_PC: st_nxt.rdata = st_r.pc;
        fie_pkg::REG_IP: st_nxt.rdata = st_r.ip;
        fie_pkg::REG_SP: st_nxt.rdata = st_r.sp;
        fie_pkg::REG_FLAGS: st_nxt.rdata = {8'h00, st_r.flags};
        fie_pkg::REG_GIC: st_nxt.rdata = {8'h00, st_r.gic};
        fie_pkg::REG_CTRL: st_nxt.rdata = {8'h00, st_r.ctrl};
        fie_pkg::REG_STATUS: st_nxt.rdata = {13'h0000, st_r.illegal,
                                             st_r.st != fie_pkg::ST_STOP, st_r.halt};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
    // Counter, thread pointer, stack pointer and flags are only writable while the core is stopped.
    if (sw.wr) begin
      case (sw.addr)
        fie_pkg::REG_PC: if (st_r.st == fie_pkg::ST_STOP) st_nxt.pc = sw.wdata;
        fie_pkg::REG_IP: if (st_r.st == fie_pkg::ST_STOP) st_nxt.ip = sw.wdata;
        fie_pkg::REG_SP: if (st_r.st == fie_pkg::ST_STOP) st_nxt.sp = sw.wdata;
        fie_pkg::REG_FLAGS: if (st_r.st == fie_pkg::ST_STOP) st_nxt.flags = sw.wdata[7:0];
        fie_pkg::REG_GIC: st_nxt.gic = sw.wdata[7:0];
        fie_pkg::REG_CTRL: st_nxt.ctrl = sw.wdata[7:0];
        fie_pkg::REG_STATUS: if (sw.wdata[fie_pkg::STS_ILLEGAL]) st_nxt.illegal = 1'b0;
        default: st_nxt.illegal = st_r.illegal;
      endcase
    end
    case (st_r.st)
      fie_pkg::ST_STOP: begin
        st_nxt.cnt = 8'h00;
        if (st_r.ctrl[fie_pkg::CTRL_RUN]) st_nxt.st = fie_pkg::ST_FETCH;
      end
      fie_pkg::ST_FETCH: begin
        st_nxt.cnt = 8'h01; // The fetch clock counts toward the instruction length.
        if (!st_r.ctrl[fie_pkg::CTRL_RUN]) begin
          st_nxt.st = fie_pkg::ST_STOP;
        end else if (st_r.irq_sync && st_r.gic[fie_pkg::GIC_EN]) begin
          st_nxt.gic[fie_pkg::GIC_EN] = 1'b0;
          if (st_r.ctrl[fie_pkg::CTRL_FAST]) begin
            st_nxt.pc = st_r.ip; // RULE12
            st_nxt.ip = st_r.pc; // RULE12
            st_nxt.shadow = st_r.flags;
            st_nxt.flags[fie_pkg::FLG_FIS] = 1'b1;
          end else begin
            st_nxt.mem = acc(1'b1, stk_spc, st_r.sp - 16'h0001, st_r.pc[7:0]);
            st_nxt.st = fie_pkg::ST_IRQ2;
          end
        end else begin
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_PROG, st_r.pc, 8'h00);
          st_nxt.pc = st_r.pc + 16'h0001;
          st_nxt.st = fie_pkg::ST_WAIT;
          st_nxt.ret = fie_pkg::ST_DECODE;
        end
      end
      fie_pkg::ST_IRQ2: begin
        st_nxt.mem = acc(1'b1, stk_spc, st_r.sp - 16'h0002, st_r.pc[15:8]);
        st_nxt.st = fie_pkg::ST_IRQ3;
      end
      fie_pkg::ST_IRQ3: begin
        st_nxt.mem = acc(1'b1, stk_spc, st_r.sp - 16'h0003, st_r.flags);
        st_nxt.sp = st_r.sp - 16'h0003;
        st_nxt.pc = irq_vector;
        st_nxt.st = fie_pkg::ST_FETCH;
      end
      fie_pkg::ST_WAIT: st_nxt.st = st_r.ret;
      fie_pkg::ST_DECODE: begin
        st_nxt.op = mem_rdata;
        st_nxt.st = fie_pkg::ST_WAIT;
        st_nxt.ret = fie_pkg::ST_OPND;
        st_nxt.budget = fie_pkg::BUD_OTHER;
        if (mem_rdata == fie_pkg::OP_EXIT) begin
          st_nxt.budget = ext_stk ? fie_pkg::BUD_EXIT_EXT : fie_pkg::BUD_EXIT_INT; // RULE1
          st_nxt.mem = acc(1'b0, stk_spc, st_r.sp, 8'h00);
          st_nxt.ret = fie_pkg::ST_RD1;
        end else if (mem_rdata == fie_pkg::OP_IDLE) begin
          st_nxt.budget = fie_pkg::BUD_IDLE;
          st_nxt.halt_pend = 1'b1; // RULE3
          st_nxt.st = fie_pkg::ST_PAD;
        end else if (mem_rdata == fie_pkg::OP_SERVICE_RETURN && st_r.flags[fie_pkg::FLG_FIS]) begin
          st_nxt.budget = fie_pkg::BUD_SERVICE_RETURN_FAST;
          st_nxt.pc = st_r.ip; // RULE12
          st_nxt.ip = st_r.pc;
          st_nxt.flags = st_r.shadow; // RULE11
          st_nxt.flags[fie_pkg::FLG_FIS] = 1'b0; // RULE10
          st_nxt.gic[fie_pkg::GIC_EN] = 1'b1; // RULE18
          st_nxt.st = fie_pkg::ST_PAD;
        end else if (mem_rdata == fie_pkg::OP_SERVICE_RETURN) begin
          st_nxt.budget = ext_stk ? fie_pkg::BUD_SERVICE_RETURN_EXT : fie_pkg::BUD_SERVICE_RETURN_INT; // RULE9
          st_nxt.mem = acc(1'b0, stk_spc, st_r.sp, 8'h00);
          st_nxt.ret = fie_pkg::ST_RD1;
        end else if (mem_rdata[3:0] == fie_pkg::LO_INC_WR) begin
          st_nxt.budget = fie_pkg::BUD_INC;
          st_nxt.addr = {8'h00, st_r.ctrl[7:4], mem_rdata[7:4]};
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_REG, {8'h00, st_r.ctrl[7:4], mem_rdata[7:4]}, 8'h00);
          st_nxt.ret = fie_pkg::ST_RD1;
        end else if (mem_rdata == fie_pkg::OP_INC_R || mem_rdata == fie_pkg::OP_INC_IR ||
                     mem_rdata == fie_pkg::OP_WORD_PLUS_ONE_RR || mem_rdata == fie_pkg::OP_WORD_PLUS_ONE_IR ||
                     mem_rdata == fie_pkg::OP_JP_IRR || mem_rdata[3:0] == fie_pkg::LO_JR_CC ||
                     mem_rdata[3:0] == fie_pkg::LO_JP_CC) begin
          if (mem_rdata == fie_pkg::OP_INC_R || mem_rdata == fie_pkg::OP_INC_IR) begin
            st_nxt.budget = fie_pkg::BUD_INC;
          end else if (mem_rdata == fie_pkg::OP_WORD_PLUS_ONE_RR || mem_rdata == fie_pkg::OP_WORD_PLUS_ONE_IR) begin
            st_nxt.budget = fie_pkg::BUD_WORD_PLUS_ONE;
          end else if (mem_rdata[3:0] == fie_pkg::LO_JR_CC && mem_rdata != fie_pkg::OP_JP_IRR) begin
            st_nxt.budget = fie_pkg::BUD_JR;
          end else begin
            st_nxt.budget = fie_pkg::BUD_JP;
          end
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_PROG, st_r.pc, 8'h00);
          st_nxt.pc = st_r.pc + 16'h0001;
        end else begin
          // Unknown opcodes run as a no_operation and leave a sticky mark.
          st_nxt.illegal = 1'b1;
          st_nxt.st = fie_pkg::ST_PAD;
        end
      end
      fie_pkg::ST_OPND: begin
        st_nxt.st = fie_pkg::ST_WAIT;
        st_nxt.ret = fie_pkg::ST_RD1;
        st_nxt.addr = {8'h00, mem_rdata};
        if (st_r.op == fie_pkg::OP_INC_IR || st_r.op == fie_pkg::OP_WORD_PLUS_ONE_IR) begin
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_REG, {8'h00, mem_rdata}, 8'h00);
          st_nxt.ret = fie_pkg::ST_PTR;
        end else if (st_r.op == fie_pkg::OP_WORD_PLUS_ONE_RR) begin
          st_nxt.addr = {8'h00, mem_rdata[7:1], 1'b0}; // RULE7
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_REG, {8'h00, mem_rdata[7:1], 1'b0}, 8'h00);
        end else if (st_r.op == fie_pkg::OP_INC_R || st_r.op == fie_pkg::OP_JP_IRR) begin
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_REG, {8'h00, mem_rdata}, 8'h00);
        end else if (st_r.op[3:0] == fie_pkg::LO_JR_CC) begin
          // The counter already points past the displacement byte.
          if (cond_true) st_nxt.pc = st_r.pc + {{8{mem_rdata[7]}}, mem_rdata}; // RULE16 RULE17
          st_nxt.st = fie_pkg::ST_PAD;
        end else begin
          st_nxt.tmp = mem_rdata;
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_PROG, st_r.pc, 8'h00);
          st_nxt.pc = st_r.pc + 16'h0001;
          st_nxt.ret = fie_pkg::ST_RD2;
        end
      end
      fie_pkg::ST_PTR: begin
        st_nxt.addr = {8'h00, mem_rdata[7:1], mem_rdata[0] & ~inc_word};
        st_nxt.mem = acc(1'b0, fie_pkg::SPC_REG,
                         {8'h00, mem_rdata[7:1], mem_rdata[0] & ~inc_word}, 8'h00);
        st_nxt.st = fie_pkg::ST_WAIT;
        st_nxt.ret = fie_pkg::ST_RD1;
      end
      fie_pkg::ST_RD1: begin
        st_nxt.tmp = mem_rdata;
        st_nxt.st = fie_pkg::ST_WAIT;
        st_nxt.ret = fie_pkg::ST_RD2;
        if (st_r.op == fie_pkg::OP_EXIT || st_r.op == fie_pkg::OP_SERVICE_RETURN) begin
          if (st_r.op == fie_pkg::OP_SERVICE_RETURN) st_nxt.flags = mem_rdata; // RULE11
          st_nxt.mem = acc(1'b0, stk_spc, st_r.sp + 16'h0001, 8'h00);
        end else if (inc_word || st_r.op == fie_pkg::OP_JP_IRR) begin
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_REG, st_r.addr + 16'h0001, 8'h00);
        end else begin
          // Carry, decimal-adjust and half-carry are left as they are.
          st_nxt.mem = acc(1'b1, fie_pkg::SPC_REG, st_r.addr, inc_res[7:0]); // RULE6
          st_nxt.flags[fie_pkg::FLG_Z] = inc_z;
          st_nxt.flags[fie_pkg::FLG_S] = inc_s;
          st_nxt.flags[fie_pkg::FLG_V] = inc_v;
          st_nxt.st = fie_pkg::ST_PAD;
        end
      end
      fie_pkg::ST_RD2: begin
        st_nxt.st = fie_pkg::ST_PAD;
        if (st_r.op == fie_pkg::OP_EXIT) begin
          st_nxt.ip = {st_r.tmp, mem_rdata}; // RULE1
          st_nxt.sp = st_r.sp + 16'h0002; // RULE1
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_PROG, {st_r.tmp, mem_rdata}, 8'h00);
          st_nxt.st = fie_pkg::ST_WAIT;
          st_nxt.ret = fie_pkg::ST_RD3;
        end else if (st_r.op == fie_pkg::OP_SERVICE_RETURN) begin
          st_nxt.tmp = mem_rdata;
          st_nxt.mem = acc(1'b0, stk_spc, st_r.sp + 16'h0002, 8'h00);
          st_nxt.st = fie_pkg::ST_WAIT;
          st_nxt.ret = fie_pkg::ST_RD3;
        end else if (inc_word) begin
          // Pair is held high byte first at the even address.
          st_nxt.mem = acc(1'b1, fie_pkg::SPC_REG, st_r.addr, inc_res[15:8]); // RULE7
          st_nxt.tmp = inc_res[7:0];
          st_nxt.flags[fie_pkg::FLG_Z] = inc_z;
          st_nxt.flags[fie_pkg::FLG_S] = inc_s;
          st_nxt.flags[fie_pkg::FLG_V] = inc_v;
          st_nxt.st = fie_pkg::ST_WR2;
        end else if (st_r.op == fie_pkg::OP_JP_IRR) begin
          st_nxt.pc = {st_r.tmp, mem_rdata}; // RULE15
        end else if (cond_true) begin
          st_nxt.pc = {st_r.tmp, mem_rdata}; // RULE14
        end
      end
      fie_pkg::ST_RD3: begin
        st_nxt.tmp = mem_rdata;
        st_nxt.st = fie_pkg::ST_PAD;
        if (st_r.op == fie_pkg::OP_SERVICE_RETURN) begin
          st_nxt.pc = {st_r.tmp, mem_rdata}; // RULE9
          st_nxt.sp = st_r.sp + 16'h0003;
          st_nxt.gic[fie_pkg::GIC_EN] = 1'b1; // RULE18
        end else begin
          st_nxt.mem = acc(1'b0, fie_pkg::SPC_PROG, st_r.ip + 16'h0001, 8'h00);
          st_nxt.st = fie_pkg::ST_WAIT;
          st_nxt.ret = fie_pkg::ST_RD4;
        end
      end
      fie_pkg::ST_RD4: begin
        st_nxt.pc = {st_r.tmp, mem_rdata}; // RULE2
        st_nxt.ip = st_r.ip + 16'h0002; // RULE2
        st_nxt.st = fie_pkg::ST_PAD;
      end
      fie_pkg::ST_WR2: begin
        st_nxt.mem = acc(1'b1, fie_pkg::SPC_REG, st_r.addr + 16'h0001, st_r.tmp);
        st_nxt.st = fie_pkg::ST_PAD;
      end
      // Padding keeps each instruction at its documented length.
      fie_pkg::ST_PAD: begin
        if (st_r.cnt >= st_r.budget - 8'h01) begin
          st_nxt.st = st_r.halt_pend ? fie_pkg::ST_HALT : fie_pkg::ST_FETCH;
          st_nxt.halt = st_r.halt_pend; // RULE3
          st_nxt.halt_pend = 1'b0;
        end
      end
      fie_pkg::ST_HALT: begin
        if (st_r.irq_sync) begin
          st_nxt.st = fie_pkg::ST_FETCH; // RULE4
          st_nxt.halt = 1'b0;
        end
      end
      default: st_nxt.st = fie_pkg::ST_STOP;
    endcase
  end

  // State register; reset also releases a halt.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.st <= fie_pkg::ST_STOP;
      st_r.ret <= fie_pkg::ST_STOP;
      st_r.pc <= fie_pkg::RST_PC;
      st_r.ip <= fie_pkg::RST_IP;
      st_r.sp <= fie_pkg::RST_SP;
      st_r.flags <= fie_pkg::RST_FLAGS;
      st_r.gic <= fie_pkg::RST_GIC;
      st_r.ctrl <= fie_pkg::RST_CTRL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mem = st_r.mem;
  assign sw_rdata = st_r.rdata;
  assign cpu_halt = st_r.halt;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !st_r.ctrl[fie_pkg::CTRL_RUN]);

  a_exit_sp_step: assert property ((st_r.st == fie_pkg::ST_DECODE && mem_rdata == 8'h2F &&
    !ext_stk) |-> ##40 (st_r.sp == $past(st_r.sp, 40) + 16'h0002 &&
    st_r.st == fie_pkg::ST_FETCH)) else $error("exit length or stack step wrong"); // RULE1
  a_exit_flags_kept: assert property ((st_r.st == fie_pkg::ST_DECODE && mem_rdata == 8'h2F)
    |-> ##4 (st_r.flags == $past(st_r.flags, 4))) else $error("exit changed flags"); // RULE2
  a_idle_halts: assert property ((st_r.st == fie_pkg::ST_DECODE && mem_rdata == 8'h6F)
    |-> (!cpu_halt) [*8] ##1 (!cpu_halt) [*2] ##1 cpu_halt)
    else $error("idle halt timing wrong"); // RULE3
  a_halt_wakes: assert property ((cpu_halt && st_r.irq_sync) |=> !cpu_halt)
    else $error("halt did not wake"); // RULE4
  a_inc_byte_value: assert property ((st_r.st == fie_pkg::ST_RD1 && st_r.op == 8'h20) |=>
    (mem.we && mem.wdata == $past(mem_rdata) + 8'h01 &&
    st_r.flags[fie_pkg::FLG_C] == $past(st_r.flags[fie_pkg::FLG_C])))
    else $error("byte increment wrong"); // RULE6
  a_word_plus_one_zero_flag: assert property ((st_r.st == fie_pkg::ST_RD2 && inc_word) |=>
    (st_r.flags[fie_pkg::FLG_Z] == ($past({st_r.tmp, mem_rdata}) == 16'hFFFF)))
    else $error("word increment zero flag wrong"); // RULE7
  a_service_return_enables: assert property ((st_r.st == fie_pkg::ST_RD3 && st_r.op == 8'hBF) |=>
    st_r.gic[0]) else $error("service return left interrupts off"); // RULE9
  a_fast_swap: assert property ((st_r.st == fie_pkg::ST_DECODE && mem_rdata == 8'hBF &&
    st_r.flags[fie_pkg::FLG_FIS]) |=> (st_r.pc == $past(st_r.ip) && st_r.ip == $past(st_r.pc)
    && !st_r.flags[fie_pkg::FLG_FIS])) else $error("fast return swap wrong"); // RULE12
  a_jp_fallthru: assert property ((st_r.st == fie_pkg::ST_RD2 && st_r.op[3:0] == 4'hD &&
    !cond_true) |=> $stable(st_r.pc)) else $error("false branch moved counter"); // RULE14
  a_jr_target: assert property ((st_r.st == fie_pkg::ST_OPND && st_r.op[3:0] == 4'hB &&
    st_r.op != 8'h30 && cond_true) |=> (st_r.pc == $past(st_r.pc) +
    {{8{$past(mem_rdata[7])}}, $past(mem_rdata)})) else $error("relative target wrong"); // RULE16

endmodule

// >>> bench/fie_mem_model.sv
// Memory model standing behind the core: program space and register file with stack.
module fie_mem_model (
  input wire logic clk,
  input wire fie_pkg::fie_mem_t mem,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] prog [0:255];
  logic [7:0] regf [0:255];
  initial mem_rdata = 8'h00;
  // Read data stands only in the cycle after the request; it toggles otherwise so stale bytes show.
  always @(posedge clk) begin
    if (mem.req && mem.we && mem.space != fie_pkg::SPC_PROG) regf[mem.addr[7:0]] <= mem.wdata;
    if (mem.req && !mem.we) begin
      mem_rdata <= (mem.space == fie_pkg::SPC_PROG) ? prog[mem.addr[7:0]] : regf[mem.addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// >>> bench/tb_flow_and_increment_execution.sv
// Self-checking bench that runs a short program through the execution core.
module tb_flow_and_increment_execution;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic irq_pin = 1'b0;
  logic [15:0] irq_vector = 16'h0090;
  fie_pkg::fie_sw_t sw = '0;
  fie_pkg::fie_mem_t mem;
  logic [15:0] sw_rdata;
  logic [7:0] mem_rdata;
  logic cpu_halt;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  fie_core fie_core_i (.clk(clk), .rst(rst), .sw(sw), .sw_rdata(sw_rdata), .irq_pin(irq_pin),
    .irq_vector(irq_vector), .mem(mem), .mem_rdata(mem_rdata), .cpu_halt(cpu_halt));
  fie_mem_model fie_mem_model_i (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));
  // A 25 ns half period gives the 20 MHz clock.
  always #25 clk = ~clk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk) sw <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) sw <= '0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled mid-cycle there.
  task automatic rd_chk(input string what, input logic [2:0] a, input logic [15:0] exp);
    @(posedge clk) sw <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk) sw <= '0;
    @(negedge clk) chk(what, exp, sw_rdata);
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] b [$]);
    foreach (b[i]) fie_mem_model_i.prog[a + 8'(i)] = b[i];
  endtask
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // The program is a chain of branches, increments, a threaded exit and an idle.
  initial begin
    put(8'h10, '{8'h20, 8'h05, 8'h4B, 8'h02, 8'hFF, 8'hFF});
    put(8'h16, '{8'h8D, 8'h00, 8'h40});
    put(8'h40, '{8'hA0, 8'h08, 8'h0D, 8'h12, 8'h34, 8'h30, 8'h0A});
    put(8'h50, '{8'h2F});
    put(8'h60, '{8'h6F, 8'h8B, 8'h00, 8'h8B, 8'h00, 8'h8B, 8'h00, 8'h8B, 8'hFE});
    put(8'h82, '{8'h8B, 8'h00, 8'hBF});
    put(8'h90, '{8'hBF});
    put(8'h80, '{8'h00, 8'h60});
    fie_mem_model_i.regf[8'h00] = 8'h00;
    fie_mem_model_i.regf[8'h01] = 8'h80;
    fie_mem_model_i.regf[8'h05] = 8'h7F;
    fie_mem_model_i.regf[8'h08] = 8'h00;
    fie_mem_model_i.regf[8'h09] = 8'hFF;
    fie_mem_model_i.regf[8'h0A] = 8'h00;
    fie_mem_model_i.regf[8'h0B] = 8'h50;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk("sp reset", fie_pkg::REG_SP, fie_pkg::RST_SP);
    rd_chk("ctrl reset", fie_pkg::REG_CTRL, 16'h0000);
    wr(fie_pkg::REG_PC, 16'h0010);
    wr(fie_pkg::REG_FLAGS, 16'h0080);
    wr(fie_pkg::REG_CTRL, 16'h0004);
    wr(fie_pkg::REG_SP, 16'h0200);
    for (n = 0; n < 2000 && cpu_halt !== 1'b1; n++) @(posedge clk);
    repeat (20) @(posedge clk);
    chk("halt", 16'h0001, {15'h0000, cpu_halt});
    @(posedge clk) irq_pin <= 1'b1;
    for (n = 0; n < 10 && cpu_halt !== 1'b0; n++) @(posedge clk);
    chk("wake", 16'h0000, {15'h0000, cpu_halt});
    @(posedge clk) irq_pin <= 1'b0;
    repeat (100) @(posedge clk);
    // Each request is held long enough to be taken once, and dropped before the return.
    wr(fie_pkg::REG_GIC, 16'h0001);
    wr(fie_pkg::REG_CTRL, 16'h0006);
    @(posedge clk) irq_pin <= 1'b1;
    repeat (24) @(posedge clk);
    irq_pin <= 1'b0;
    repeat (100) @(posedge clk);
    wr(fie_pkg::REG_CTRL, 16'h0004);
    @(posedge clk) irq_pin <= 1'b1;
    repeat (24) @(posedge clk);
    irq_pin <= 1'b0;
    repeat (100) @(posedge clk);
    wr(fie_pkg::REG_CTRL, 16'h0000);
    repeat (100) @(posedge clk);
    rd_chk("pc", fie_pkg::REG_PC, 16'h0067);
    rd_chk("ip", fie_pkg::REG_IP, 16'h0085);
    rd_chk("gic", fie_pkg::REG_GIC, 16'h0001);
    chk("pushed pc low", 16'h0067, {8'h00, fie_mem_model_i.regf[8'h01]});
    chk("pushed flags", 16'h0080, {8'h00, fie_mem_model_i.regf[8'hFF]});
    rd_chk("sp", fie_pkg::REG_SP, 16'h0102);
    rd_chk("flags", fie_pkg::REG_FLAGS, 16'h0080);
    rd_chk("status", fie_pkg::REG_STATUS, 16'h0000);
    chk("byte inc", 16'h0080, {8'h00, fie_mem_model_i.regf[8'h05]});
    chk("word inc", 16'h0100, {fie_mem_model_i.regf[8'h08], fie_mem_model_i.regf[8'h09]});
    stop_test();
  end
  // The program needs well under a thousand cycles; this bound cuts a hang short.
  initial begin
    #1000000;
    miscompares++;
    stop_test();
  end
endmodule
